// [inc/swc_map.svh]
/*
  Constants of the timing-reference window capture block: widths, positions, reset values.
  Assumes inclusion by bare name from files that need them.
*/
`ifndef SWC_MAP_SVH
`define SWC_MAP_SVH
`define SWC_NUM_POS       24
`define SWC_NUM_SEL       16
`define SWC_SEL_W         4
`define SWC_POS_FIRST     0
`define SWC_POS_LAST      23
`define SWC_STATUS_RST    24'hffffff
`define SWC_SEL_RST       4'h0
`define SWC_SYNC_STAGES   2
`endif

// [inc/swc_pkg.sv]
/*
  Types of the timing-reference window capture block.
  Assumes swc_map.svh is on the include path.
*/
`include "swc_map.svh"
package swc_pkg;
  typedef logic [`SWC_NUM_POS-1:0] swc_vec_t;
  typedef logic [`SWC_SEL_W-1:0]   swc_sel_t;
endpackage : swc_pkg

// [core/swc_window_capture.sv]
/*
  Timing-reference position detector and delayed-sample capture.
  Assumes an analog delay line outside presents the reference as sampled by each of 24
  delayed copies of the active input clock, in coarse and fine spacing, asynchronously.
*/
`timescale 1ns/10ps
`include "swc_map.svh"

// What this block does
// - Reference is captured on a deterministic clock edge, whichever clock input is used.
// - Detect reference position, then sample with the chosen delayed clock copy.
// - Each status bit is one delay: 1 means setup or hold risk, 0 valid.
// - Select field holds the status bit index; that delay samples the reference.
// - Fine-step control 0 gives coarse delay steps, 1 gives fine steps.
// - Status bits 0 and 23 always read as 1.
// - Status shows 24 positions; select reaches only the first 16.
module swc_window_capture
  import swc_pkg::*;
#(
  parameter int NUM_POS = `SWC_NUM_POS,
  parameter int NUM_SEL = `SWC_NUM_SEL
) (
  input  wire logic     clock,
  input  wire logic     rstn,
  input  wire swc_vec_t ref_taps_coarse,
  input  wire swc_vec_t ref_taps_fine,
  input  wire logic     fine_step_control,
  input  wire swc_sel_t capture_delay_select,
  output swc_vec_t      window_status_vector,
  output logic          ref_captured,
  output logic          ref_capture_pulse
);

  if (NUM_POS != `SWC_NUM_POS || NUM_SEL != `SWC_NUM_SEL || NUM_SEL > NUM_POS) begin : g_chk
    $error("swc_window_capture: unsupported position or select count");
  end

  // Pins cross from the delay-line domain; two flops before any logic looks
  swc_vec_t coarse_s1_r;
  swc_vec_t coarse_s2_r;
  swc_vec_t fine_s1_r;
  swc_vec_t fine_s2_r;
  logic     fine_s1_ctl_r;
  logic     fine_ctl_r;
  swc_sel_t sel_s1_r;
  swc_sel_t sel_r;

  swc_vec_t window_status_r;
  swc_vec_t window_status_nxt;
  logic     captured_r;
  logic     captured_nxt;
  logic     pulse_r;
  logic     pulse_nxt;

  wire swc_vec_t taps;
  wire swc_vec_t viol;
  wire logic     transition_seen;

  assign taps = fine_ctl_r ? fine_s2_r : coarse_s2_r;

  // A position is at risk when its sample disagrees with a neighbour
  for (genvar i = 0; i < NUM_POS; i++) begin : g_pos
    if (i == `SWC_POS_FIRST || i == `SWC_POS_LAST) begin : g_end
      assign viol[i] = 1'b1;
    end else begin : g_mid
      assign viol[i] = (taps[i] != taps[i-1]) | (taps[i] != taps[i+1]);
    end
  end

  // With no edge inside the window there is nothing to judge, so the last result holds
  assign transition_seen   = (taps != '0) && (taps != '1);
  assign window_status_nxt = transition_seen ? viol : window_status_r;
  // Select is 4 bits, so only positions 0..15 can ever be sampled
  assign captured_nxt      = taps[sel_r];
  assign pulse_nxt         = captured_nxt & ~captured_r;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      coarse_s1_r   <= '0;
      coarse_s2_r   <= '0;
      fine_s1_r     <= '0;
      fine_s2_r     <= '0;
      fine_s1_ctl_r <= 1'b0;
      fine_ctl_r    <= 1'b0;
      sel_s1_r      <= `SWC_SEL_RST;
      sel_r         <= `SWC_SEL_RST;
    end else begin
      coarse_s1_r   <= ref_taps_coarse;
      coarse_s2_r   <= coarse_s1_r;
      fine_s1_r     <= ref_taps_fine;
      fine_s2_r     <= fine_s1_r;
      fine_s1_ctl_r <= fine_step_control;
      fine_ctl_r    <= fine_s1_ctl_r;
      sel_s1_r      <= capture_delay_select;
      sel_r         <= sel_s1_r;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      window_status_r <= `SWC_STATUS_RST;
      captured_r      <= 1'b0;
      pulse_r         <= 1'b0;
    end else begin
      window_status_r <= window_status_nxt;
      captured_r      <= captured_nxt;
      pulse_r         <= pulse_nxt;
    end
  end

  assign window_status_vector = window_status_r;
  assign ref_captured         = captured_r;
  assign ref_capture_pulse    = pulse_r;

  // Assertion helper only: counts edges since reset let go, so no $past looks into reset
  // Saturates at three, the deepest look-back that any property below makes
  // It drives no output, so synthesis may drop it
  logic [1:0] sync_age_r;
  logic [1:0] sync_age_nxt;
  wire logic  sync_full;

  assign sync_full    = (sync_age_r == 2'h3);
  assign sync_age_nxt = sync_full ? sync_age_r : sync_age_r + 2'h1;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sync_age_r <= 2'h0;
    end else begin
      sync_age_r <= sync_age_nxt;
    end
  end

  sequence s_rise;
    !captured_r ##1 captured_r;
  endsequence

  // A falling capture is not an event of its own
  sequence s_fall;
    captured_r ##1 !captured_r;
  endsequence

  // A select change in flight would make the capture follow an older index
  sequence s_sel_steady;
    sync_full && $stable(sel_r) ##1 $stable(sel_r);
  endsequence

  AST_END_BITS_SET: assert property (@(posedge clock) disable iff (!rstn)
    window_status_r[`SWC_POS_FIRST] && window_status_r[`SWC_POS_LAST])
    else $error("end status bits not set");

  AST_VALID_BIT_ZERO: assert property (@(posedge clock) disable iff (!rstn)
    (transition_seen && taps[4] == taps[3] && taps[4] == taps[5]) |=> !window_status_r[4])
    else $error("steady position reported as risky");

  AST_RISK_BIT_ONE: assert property (@(posedge clock) disable iff (!rstn)
    (transition_seen && taps[8] != taps[9]) |=> (window_status_r[8] && window_status_r[9]))
    else $error("edge position not reported as risky");

  AST_STATUS_HOLDS: assert property (@(posedge clock) disable iff (!rstn)
    !transition_seen |=> $stable(window_status_r))
    else $error("status changed without a transition");

  AST_SELECT_SAMPLES: assert property (@(posedge clock) disable iff (!rstn)
    1'b1 |=> captured_r == $past(taps[sel_r]))
    else $error("capture does not follow selected delay");

  AST_STEP_SPACING: assert property (@(posedge clock) disable iff (!rstn)
    s_sel_steady |=> captured_r == ($past(fine_step_control, 3)
                                    ? $past(ref_taps_fine[sel_r], 3)
                                    : $past(ref_taps_coarse[sel_r], 3)))
    else $error("step spacing selection wrong");

  AST_SELECT_RANGE: assert property (@(posedge clock) disable iff (!rstn)
    sel_r < NUM_SEL)
    else $error("select beyond first sixteen positions");

  AST_EDGE_PULSE: assert property (@(posedge clock) disable iff (!rstn)
    s_rise |-> pulse_r ##1 !pulse_r)
    else $error("capture edge pulse missing or long");

  AST_PULSE_CAUSE: assert property (@(posedge clock) disable iff (!rstn)
    pulse_r |-> (captured_r && !$past(captured_r)))
    else $error("pulse without captured rising edge");

  AST_PULSE_ONE_CYCLE: assert property (@(posedge clock) disable iff (!rstn)
    pulse_r |=> !pulse_r)
    else $error("capture pulse longer than one cycle");

  AST_NO_PULSE_ON_FALL: assert property (@(posedge clock) disable iff (!rstn)
    s_fall |-> !pulse_r)
    else $error("pulse on falling capture");

  // Bits past the select range are judged like the rest, for information only
  AST_INFO_EDGE: assert property (@(posedge clock) disable iff (!rstn)
    (transition_seen && taps[15] != taps[16]) |=> (window_status_r[15] && window_status_r[16]))
    else $error("edge at select boundary not reported");

  // Inputs are asynchronous; these hold only while they change off the sampling edge
  AST_SYNC_FINE: assert property (@(posedge clock) disable iff (!rstn)
    sync_full |-> fine_ctl_r == $past(fine_step_control, 2))
    else $error("fine-step control not taken after two flops");

  AST_SYNC_SELECT: assert property (@(posedge clock) disable iff (!rstn)
    sync_full |-> sel_r == $past(capture_delay_select, 2))
    else $error("select not taken after two flops");

  AST_SYNC_COARSE: assert property (@(posedge clock) disable iff (!rstn)
    sync_full |-> coarse_s2_r == $past(ref_taps_coarse, 2))
    else $error("coarse taps not taken after two flops");

  AST_SYNC_FINE_TAPS: assert property (@(posedge clock) disable iff (!rstn)
    sync_full |-> fine_s2_r == $past(ref_taps_fine, 2))
    else $error("fine taps not taken after two flops");

endmodule : swc_window_capture

// [dv/swc_ref_source.sv]
/*
  Clock source model: the timing reference as seen by the delay taps.
  Assumes the bench sets the window bounds off the rising edge.
*/
`timescale 1ns/10ps
module swc_ref_source
  import swc_pkg::*;
(
  input  wire logic       active,
  input  wire logic [4:0] lo,
  input  wire logic [4:0] hi,
  output swc_vec_t        taps_c,
  output swc_vec_t        taps_f
);
  swc_vec_t win;
  always_comb for (int i = 0; i < 24; i++) win[i] = (i >= lo) && (i <= hi);
  // Reads low between pulses, so a single pulse leaves the status held
  assign taps_c = active ? win : '0;
  assign taps_f = active ? (win << 2) : '0;
endmodule : swc_ref_source

// [dv/swc_window_capture_tb_top.sv]
/*
  Row-driven bench for the window capture block.
  Assumes the source model and the design; no other stimulus.
*/
`timescale 1ns/10ps
module swc_window_capture_tb_top
  import swc_pkg::*;
;
  typedef struct packed {logic f; logic a; logic [4:0] lo; logic [4:0] hi;
    swc_sel_t s; swc_vec_t st; logic c;} swc_row_t;
  logic       clock, rstn, fine, active, cap, pulse;
  logic [4:0] lo, hi;
  swc_sel_t   sel;
  swc_vec_t   taps_c, taps_f, status;
  int         n_fail = 0, check_count = 0, np;
  localparam int REF_PERIOD_8B  = 10 * 1 * 4 * 1 / 1; // F=1 K=4 n=1 R=1
  localparam int REF_PERIOD_64B = 66 * 32 * 1 * 1 / 32; // E=1 n=1 R=32
  swc_row_t   rows [5] = '{'{1'b0, 1'b1, 5'h05, 5'h09, 4'h7, 24'h800631, 1'b1},
    '{1'b1, 1'b1, 5'h05, 5'h09, 4'h3, 24'h8018c1, 1'b0},
    '{1'b0, 1'b1, 5'h10, 5'h14, 4'hf, 24'hb18001, 1'b0},
    '{1'b1, 1'b1, 5'h0d, 5'h14, 4'hf, 24'hc0c001, 1'b1},
    '{1'b1, 1'b0, 5'h0d, 5'h14, 4'hf, 24'hc0c001, 1'b0}};
  always #50 clock = ~clock;
  swc_ref_source i_swc_ref_source (.active(active), .lo(lo), .hi(hi), .taps_c(taps_c),
    .taps_f(taps_f));
  swc_window_capture i_swc_window_capture (.clock(clock), .rstn(rstn),
    .ref_taps_coarse(taps_c), .ref_taps_fine(taps_f), .fine_step_control(fine),
    .capture_delay_select(sel), .window_status_vector(status), .ref_captured(cap),
    .ref_capture_pulse(pulse));
  task automatic check(input swc_vec_t seen, input swc_vec_t exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : wrap_up
  initial begin
    clock = 1'b0; rstn = 1'b0; fine = 1'b0; active = 1'b0;
    lo = 5'h00; hi = 5'h00; sel = 4'h0;
    repeat (12) @(negedge clock);
    rstn = 1'b1;
    for (int k = 0; k < 5; k++) begin
      {fine, active, lo, hi, sel} = {rows[k].f, rows[k].a, rows[k].lo, rows[k].hi, rows[k].s};
      repeat (4) @(negedge clock);
      check(status, rows[k].st);
      check(swc_vec_t'(cap), swc_vec_t'(rows[k].c));
      $display("row %0d done", k);
    end
    // Rising capture must give exactly one pulse cycle
    active = 1'b1;
    np = 0;
    repeat (6) begin
      @(negedge clock);
      if (pulse === 1'b1) np++;
    end
    check(swc_vec_t'(np), 24'h000001);
    check(swc_vec_t'(cap), 24'h000001);
    $display("pulse test done");
    rstn = 1'b0;
    @(negedge clock);
    check(status, 24'hffffff);
    check(swc_vec_t'({cap, pulse}), 24'h000000);
    $display("reset test done");
    rstn = 1'b1;
    @(negedge clock);
    check(status, 24'hffffff);
    check(swc_vec_t'({cap, pulse}), 24'h000000);
    @(negedge clock);
    check(status, 24'hffffff);
    repeat (2) @(negedge clock);
    check(status, 24'hc0c001);
    check(swc_vec_t'({cap, pulse}), 24'h000002);
    $display("reset release done");
    active = 1'b0;
    repeat (4) @(negedge clock);
    for (int m = 0; m < 2; m++) begin
      np = 0;
      repeat (4) begin
        active = ~active;
        repeat ((m == 0) ? REF_PERIOD_8B / 2 : REF_PERIOD_64B / 2) begin
          @(negedge clock);
          if (pulse === 1'b1) np++;
        end
      end
      check(swc_vec_t'(np), 24'h000002);
      $display("periodic test %0d done", m);
    end
    wrap_up();
  end
endmodule : swc_window_capture_tb_top
